// ==== hw/ebpm_top.sv ====
// Behaviour
// - dma request pin sampled always when chosen as start source; port drive then off
// - dma acknowledge drives shared pin only while ack setting enabled
// - shared ack pin is port b bit 4 when ack and end settings both disabled
// - dma transfer-end drives shared ack pin only while end setting enabled
// - dma stop input recognised only while stop input setting enabled
// - stop pin is port b bit 5 only when end and stop both disabled
// - fly-by write strobe on pin when enabled, else port b bit 6
// - fly-by read strobe on pin when enabled, else port b bit 7
// - each of eight area selects has own enable, else port a bit
// - ready honoured only while enabled, else pin is port 8 bit 0
// - grant driven low while bus released, when grant setting enabled
// - grant setting disabled makes grant pin port 8 bit 1
// - request setting disabled makes request pin port 8 bit 2
// - dedicated read strobe output, never shared
// - sram mode: write strobe a carries upper byte mask
// - sram mode: write strobe b carries lower byte mask
// - write strobe b enable off makes pin port 8 bit 5
// - sram write strobe driven only while enabled, else port 9 bit 7
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`include "ebpm_params.svh"
`timescale 1ns/1ns
`default_nettype none
module ebpm_top (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // axi4-lite slave
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output ebpm_pkg::ebpm_resp_e     s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [11:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output ebpm_pkg::ebpm_resp_e     s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // internal function sources
  input  wire logic                dma_ack_int,
  input  wire logic                dma_end_int,
  input  wire logic                flyby_wr_int,
  input  wire logic                flyby_rd_int,
  input  wire logic [7:0]          area_sel_int,
  input  wire logic                bus_rd_int,
  input  wire logic                bus_wr_a_int,
  input  wire logic                bus_wr_b_int,
  input  wire logic                sram_we_int,
  input  wire logic                sram_ub_int,
  input  wire logic                sram_lb_int,
  input  wire logic                bus_cycle_start,
  // pins as in/out/oe triples
  input  wire ebpm_pkg::ebpm_port_t pin_in,
  output ebpm_pkg::ebpm_port_t     pin_out,
  output ebpm_pkg::ebpm_port_t     pin_oe,
  output logic                     bus_read_strobe_n,
  // decoded inputs to the core
  output logic                     dma_request_ch1,
  output logic                     dma_stop_ch1,
  output logic                     bus_wait,
  output logic                     bus_released
);
  import ebpm_pkg::*;

  // pin index map in pin_in/pin_out/pin_oe
  localparam int P_DREQ = 0;
  localparam int P_ACK  = 1;
  localparam int P_STOP = 2;
  localparam int P_FWR  = 3;
  localparam int P_FRD  = 4;
  localparam int P_CS0  = 5;
  localparam int P_RDY  = 13;
  localparam int P_GNT  = 14;
  localparam int P_REQ  = 15;
  // the strobe pins follow the port image bits above 15 would overflow,
  // so they take register bits 18:16 via a second vector
  logic [2:0] strobe_pin_unused;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [10:0] func_en;
  logic [7:0]  cs_en;
  logic        sram_mode;
  logic [15:0] port_out;
  logic [15:0] port_dir;
  logic [2:0]  strb_out;
  logic [2:0]  strb_dir;
  logic        bus_busy;
  ebpm_bus_e   bus_st;

  // ****************************************************************
  // axi4-lite write path
  // ****************************************************************
  logic        aw_held, w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire         do_write = aw_held && w_held && !s_axi_bvalid;
  wire         wr_hit = (aw_addr == `EBPM_OFF_FUNC_EN) || (aw_addr == `EBPM_OFF_CS_EN) ||
                        (aw_addr == `EBPM_OFF_MODE) || (aw_addr == `EBPM_OFF_PORT_OUT) ||
                        (aw_addr == `EBPM_OFF_PORT_DIR) || (aw_addr == `EBPM_OFF_PIN_STAT) ||
                        (aw_addr == `EBPM_OFF_BUS_CTRL);
  wire         wr_low  = w_strb[0];
  wire         wr_high = w_strb[1];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= EBPM_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? EBPM_OKAY : EBPM_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      func_en   <= `EBPM_RST_FUNC_EN;
      cs_en     <= `EBPM_RST_CS_EN;
      sram_mode <= 1'b0;
      port_out  <= `EBPM_RST_PORT;
      port_dir  <= `EBPM_RST_PORT;
      strb_out  <= 3'h0;
      strb_dir  <= 3'h0;
    end else if (do_write) begin
      case (aw_addr)
        `EBPM_OFF_FUNC_EN: begin
          if (wr_low) func_en[7:0] <= w_data[7:0];
          if (wr_high) func_en[10:8] <= w_data[10:8];
        end
        `EBPM_OFF_CS_EN: if (wr_low) cs_en <= w_data[7:0];
        `EBPM_OFF_MODE: if (wr_low) sram_mode <= w_data[0];
        `EBPM_OFF_PORT_OUT: begin
          if (wr_low) port_out[7:0] <= w_data[7:0];
          if (wr_high) port_out[15:8] <= w_data[15:8];
          if (w_strb[2]) strb_out <= w_data[18:16];
        end
        `EBPM_OFF_PORT_DIR: begin
          if (wr_low) port_dir[7:0] <= w_data[7:0];
          if (wr_high) port_dir[15:8] <= w_data[15:8];
          if (w_strb[2]) strb_dir <= w_data[18:16];
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // pin selection
  // ****************************************************************
  wire en_ack   = func_en[`EBPM_FE_ACK];
  wire en_end   = func_en[`EBPM_FE_END];
  wire en_stop  = func_en[`EBPM_FE_STOP];
  wire en_rdy   = func_en[`EBPM_FE_RDY];
  wire en_gnt   = func_en[`EBPM_FE_GRANT];
  wire en_req   = func_en[`EBPM_FE_REQ];
  wire en_dreq  = func_en[`EBPM_FE_DREQSRC];
  wire en_wrb   = func_en[`EBPM_FE_WRB];
  wire en_sramwe = func_en[`EBPM_FE_SRAMWE];

  // ack outranks end when both are set
  wire ack_val  = en_ack ? dma_ack_int : dma_end_int;
  wire ack_func = en_ack || en_end;
  // stop pin stays a port only if neither end nor stop owns it
  wire stop_gp  = !en_end && !en_stop;

  logic [15:0] func_sel;
  logic [15:0] func_val;
  always_comb begin
    func_sel = 16'h0000;
    func_val = 16'h0000;
    func_sel[P_DREQ] = en_dreq;
    func_sel[P_ACK]  = ack_func;
    func_val[P_ACK]  = ack_val;
    func_sel[P_STOP] = !stop_gp;
    func_sel[P_FWR]  = func_en[`EBPM_FE_FLYWR];
    func_val[P_FWR]  = flyby_wr_int;
    func_sel[P_FRD]  = func_en[`EBPM_FE_FLYRD];
    func_val[P_FRD]  = flyby_rd_int;
    func_sel[P_CS0 +: 8] = cs_en;
    func_val[P_CS0 +: 8] = area_sel_int;
    func_sel[P_RDY]  = en_rdy;
    func_sel[P_GNT]  = en_gnt;
    func_val[P_GNT]  = !bus_released;
    func_sel[P_REQ]  = en_req;
  end
  // pins that are functional inputs are never driven
  // dreq, stop, ready and request are inputs; grant (bit 14) is an output
  wire [15:0] func_is_out = 16'h5ffa & func_sel;
  wire [15:0] next_oe  = func_is_out | (~func_sel & port_dir);
  wire [15:0] next_out = (func_is_out & func_val) | (~func_sel & port_out);

  // write strobe pins: a, b (port 8 bit 5), sram write (port 9 bit 7)
  wire next_wra = sram_mode ? sram_ub_int : bus_wr_a_int;
  wire next_wrb = !en_wrb ? strb_out[1] : (sram_mode ? sram_lb_int : bus_wr_b_int);
  wire next_we  = (sram_mode && en_sramwe) ? sram_we_int : strb_out[2];
  wire we_oe    = (sram_mode && en_sramwe) || strb_dir[2];
  wire wrb_oe   = en_wrb || strb_dir[1];

  // ****************************************************************
  // bus release and wait handling
  // ****************************************************************
  wire req_act  = en_req && pin_in[P_REQ];
  wire rdy_low  = en_rdy && !pin_in[P_RDY];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bus_st <= EBPM_BUS_IDLE;
    end else begin
      case (bus_st)
        EBPM_BUS_IDLE: begin
          if (req_act) bus_st <= EBPM_BUS_RELEASED;
          else if (bus_cycle_start) bus_st <= EBPM_BUS_ACTIVE;
        end
        EBPM_BUS_ACTIVE: if (!rdy_low) bus_st <= EBPM_BUS_IDLE;
        EBPM_BUS_RELEASED: if (!req_act) bus_st <= EBPM_BUS_IDLE;
        default: bus_st <= EBPM_BUS_IDLE;
      endcase
    end
  end
  assign bus_busy = (bus_st == EBPM_BUS_ACTIVE);

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  logic [2:0] strb_reg;
  logic [2:0] strb_oe_reg;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_out           <= 16'h0000;
      pin_oe            <= 16'h0000;
      strb_reg          <= 3'h7;
      strb_oe_reg       <= 3'h0;
      bus_read_strobe_n <= 1'b1;
      dma_request_ch1   <= 1'b0;
      dma_stop_ch1      <= 1'b0;
      bus_wait          <= 1'b0;
      bus_released      <= 1'b0;
    end else begin
      pin_out           <= next_out;
      pin_oe            <= next_oe;
      strb_reg          <= {next_we, next_wrb, next_wra};
      strb_oe_reg       <= {we_oe, wrb_oe, 1'b1};
      bus_read_strobe_n <= bus_rd_int;
      dma_request_ch1   <= en_dreq && pin_in[P_DREQ];
      dma_stop_ch1      <= en_stop && pin_in[P_STOP];
      bus_wait          <= bus_busy && rdy_low;
      bus_released      <= (bus_st == EBPM_BUS_RELEASED);
    end
  end
  assign strobe_pin_unused = strb_oe_reg;

  // ****************************************************************
  // axi4-lite read path
  // ****************************************************************
  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      `EBPM_OFF_FUNC_EN:  rd_mux = {21'h0, func_en};
      `EBPM_OFF_CS_EN:    rd_mux = {24'h0, cs_en};
      `EBPM_OFF_MODE:     rd_mux = {31'h0, sram_mode};
      `EBPM_OFF_PORT_OUT: rd_mux = {13'h0, strb_out, port_out};
      `EBPM_OFF_PORT_DIR: rd_mux = {13'h0, strb_dir, port_dir};
      `EBPM_OFF_PIN_STAT: rd_mux = {13'h0, strb_reg, pin_in};
      `EBPM_OFF_BUS_CTRL: rd_mux = {29'h0, bus_wait, bus_released, bus_busy};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end
  wire rd_hit = (s_axi_araddr <= `EBPM_OFF_BUS_CTRL) && (s_axi_araddr[1:0] == 2'h0);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= EBPM_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? EBPM_OKAY : EBPM_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_ACK_PRIO: assert property (@(posedge mclk) disable iff (!rst_n)
    en_ack ##1 1'b1 |-> pin_out[P_ACK] == $past(dma_ack_int))
    else $error("ack pin not showing acknowledge");
  AST_ACK_GPIO: assert property (@(posedge mclk) disable iff (!rst_n)
    !en_ack && !en_end |=> pin_oe[P_ACK] == $past(port_dir[P_ACK]))
    else $error("ack pin not port bit");
  AST_STOP_IN: assert property (@(posedge mclk) disable iff (!rst_n)
    !en_stop |=> !dma_stop_ch1)
    else $error("stop seen while disabled");
  AST_STOP_NODRV: assert property (@(posedge mclk) disable iff (!rst_n)
    !stop_gp |=> !pin_oe[P_STOP])
    else $error("stop pin driven while functional");
  AST_CS_SEL: assert property (@(posedge mclk) disable iff (!rst_n)
    cs_en[0] |=> pin_oe[P_CS0] && pin_out[P_CS0] == $past(area_sel_int[0]))
    else $error("area select 0 not on pin");
  AST_GRANT: assert property (@(posedge mclk) disable iff (!rst_n)
    en_gnt && bus_released |=> !pin_out[P_GNT])
    else $error("grant not low while released");
  AST_WAIT: assert property (@(posedge mclk) disable iff (!rst_n)
    bus_busy && rdy_low |=> bus_wait ##0 bus_st == EBPM_BUS_ACTIVE)
    else $error("cycle not stretched");
  AST_DREQ_NODRV: assert property (@(posedge mclk) disable iff (!rst_n)
    en_dreq |=> !pin_oe[P_DREQ])
    else $error("request pin driven");
  AST_REQ_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
    !en_req |=> bus_st != EBPM_BUS_RELEASED)
    else $error("release with request disabled");
  COV_RELEASE: cover property (@(posedge mclk) disable iff (!rst_n) req_act ##1 bus_released);
  COV_WAIT:    cover property (@(posedge mclk) disable iff (!rst_n) bus_wait [*3]);
  COV_BOTH:    cover property (@(posedge mclk) disable iff (!rst_n) en_ack && en_end);
endmodule
`default_nettype wire

// ==== include/ebpm_params.svh ====
`ifndef EBPM_PARAMS_SVH
`define EBPM_PARAMS_SVH
// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define EBPM_OFF_FUNC_EN   12'h000
`define EBPM_OFF_CS_EN     12'h004
`define EBPM_OFF_MODE      12'h008
`define EBPM_OFF_PORT_OUT  12'h00c
`define EBPM_OFF_PORT_DIR  12'h010
`define EBPM_OFF_PIN_STAT  12'h014
`define EBPM_OFF_BUS_CTRL  12'h018
// ****************************************************************
// field positions of the function enable register
// ****************************************************************
`define EBPM_FE_ACK        0
`define EBPM_FE_END        1
`define EBPM_FE_STOP       2
`define EBPM_FE_FLYWR      3
`define EBPM_FE_FLYRD      4
`define EBPM_FE_RDY        5
`define EBPM_FE_GRANT      6
`define EBPM_FE_REQ        7
`define EBPM_FE_WRB        8
`define EBPM_FE_SRAMWE     9
`define EBPM_FE_DREQSRC    10
`define EBPM_FE_WIDTH      11
// ****************************************************************
// reset values
// ****************************************************************
`define EBPM_RST_FUNC_EN   11'h000
`define EBPM_RST_CS_EN     8'h00
`define EBPM_RST_PORT      16'h0000
`define EBPM_PORT_W        16
`endif

// ==== include/ebpm_pkg.sv ====
package ebpm_pkg;
  typedef enum logic [1:0] {
    EBPM_OKAY   = 2'h0,
    EBPM_SLVERR = 2'h2
  } ebpm_resp_e;
  typedef logic [15:0] ebpm_port_t;
  typedef enum {
    EBPM_BUS_IDLE,
    EBPM_BUS_ACTIVE,
    EBPM_BUS_RELEASED
  } ebpm_bus_e;
endpackage

// ==== tb/ebpm_far_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module ebpm_far_model (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire ebpm_pkg::ebpm_port_t pin_out,
  input  wire ebpm_pkg::ebpm_port_t pin_oe,
  input  wire logic                 bus_cycle_start,
  input  wire logic                 master_req,
  input  wire logic                 dreq,
  input  wire logic                 stop,
  input  wire logic [3:0]           wait_len,
  output ebpm_pkg::ebpm_port_t      pin_in
);
  import ebpm_pkg::*;
  logic [3:0] wait_cnt;
  logic       toggle;
  ebpm_port_t ext;
  // ****************************************************************
  // slow memory, dma peripheral and bus master
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wait_cnt <= 4'h0;
      toggle   <= 1'b0;
    end else begin
      toggle <= ~toggle;
      if (bus_cycle_start) begin
        wait_cnt <= wait_len;
      end else if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
    end
  end
  // unowned lines wander so a stale level never passes for a driven one
  always_comb begin
    ext     = {16{toggle}};
    ext[0]  = dreq;
    ext[2]  = stop;
    ext[13] = (wait_cnt == 4'h0);
    ext[15] = master_req;
  end
  // design wins where it enables its driver
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule
`default_nettype wire

// ==== tb/ebpm_top_tb.sv ====
`include "ebpm_params.svh"
`timescale 1ns/1ns
`default_nettype none
module ebpm_top_tb;
  import ebpm_pkg::*;
  logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  ebpm_resp_e  bresp, rresp, rs;
  logic        dack, dend, fwr, frd, brd, wra, wrb, swe, sub, slb, cyc_go;
  logic        rd_n, dreq_o, stop_o, bwait, brel, mreq, dreq, stop;
  logic [7:0]  asel, cs;
  logic [3:0]  wlen;
  ebpm_port_t  pin_in, pin_out, pin_oe;
  logic [15:0] po, dir, eo, ee;
  int          error_cnt, checks, cycles;
  logic [10:0] fe_tbl [9] = '{11'h000, 11'h001, 11'h002, 11'h003, 11'h004, 11'h018,
                              11'h0e0, 11'h400, 11'h4ff};

  ebpm_top DUT (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dma_ack_int(dack), .dma_end_int(dend), .flyby_wr_int(fwr), .flyby_rd_int(frd),
    .area_sel_int(asel), .bus_rd_int(brd), .bus_wr_a_int(wra), .bus_wr_b_int(wrb),
    .sram_we_int(swe), .sram_ub_int(sub), .sram_lb_int(slb), .bus_cycle_start(cyc_go),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .bus_read_strobe_n(rd_n),
    .dma_request_ch1(dreq_o), .dma_stop_ch1(stop_o), .bus_wait(bwait), .bus_released(brel));

  ebpm_far_model far (.mclk(mclk), .rst_n(rst_n), .pin_out(pin_out), .pin_oe(pin_oe),
    .bus_cycle_start(cyc_go), .master_req(mreq), .dreq(dreq), .stop(stop),
    .wait_len(wlen), .pin_in(pin_in));

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;
  // ****************************************************************
  // reporting
  // ****************************************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // ****************************************************************
  // axi4-lite master; waits are cut short only by the cycle ceiling
  // ****************************************************************
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input ebpm_resp_e er);
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
    chk(rs, er);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                        input ebpm_resp_e er);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
    chk(rs, er);
    chk(rd & m, e);
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) @(posedge mclk);
    chk(s, v);
  endtask
  // expected pin drive for a given setting
  function automatic void calc(input logic [10:0] fe, input logic [7:0] c);
    eo = po;
    ee = dir;
    if (fe[10]) ee[0] = 1'b0;
    if (fe[0] || fe[1]) begin
      ee[1] = 1'b1;
      eo[1] = fe[0] ? dack : dend;
    end
    if (fe[1] || fe[2]) ee[2] = 1'b0;
    if (fe[3]) {ee[3], eo[3]} = {1'b1, fwr};
    if (fe[4]) {ee[4], eo[4]} = {1'b1, frd};
    for (int i = 0; i < 8; i++) if (c[i]) {ee[5+i], eo[5+i]} = {1'b1, asel[i]};
    if (fe[5]) ee[13] = 1'b0;
    if (fe[6]) {ee[14], eo[14]} = {1'b1, ~(fe[7] & mreq)};
    if (fe[7]) ee[15] = 1'b0;
  endfunction
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, cyc_go, mreq, dreq, stop} = '0;
    {awaddr, araddr, wdata, asel, wlen} = '0;
    {dack, dend, fwr, frd, wra, wrb, swe, sub, slb} = '0;
    brd = 1'b1;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(pin_oe, 16'h0000);
    chk(rd_n, 1'b1);
    rd_chk(`EBPM_OFF_FUNC_EN, 32'hffffffff, 32'h0, EBPM_OKAY);
    rd_chk(`EBPM_OFF_CS_EN, 32'hffffffff, 32'h0, EBPM_OKAY);
    rd_chk(12'h020, 32'hffffffff, 32'h0, EBPM_SLVERR);
    wr(12'h024, 32'h1, EBPM_SLVERR);
    $display("test reset done");
    for (int p = 0; p < 2; p++) begin
      {dack, dend, fwr, frd} <= p ? 4'b0101 : 4'b1010;
      asel <= p ? 8'h69 : 8'h96;
      po = p ? 16'ha5c3 : 16'h5a3c;
      dir = p ? 16'h0000 : 16'hffff;
      wr(`EBPM_OFF_PORT_OUT, {16'h0, po}, EBPM_OKAY);
      wr(`EBPM_OFF_PORT_DIR, {16'h0, dir}, EBPM_OKAY);
      for (int i = 0; i < 9; i++) begin
        cs = 8'h01 << i;
        wr(`EBPM_OFF_FUNC_EN, {21'h0, fe_tbl[i]}, EBPM_OKAY);
        wr(`EBPM_OFF_CS_EN, {24'h0, cs}, EBPM_OKAY);
        repeat (3) @(posedge mclk);
        calc(fe_tbl[i], cs);
        chk(pin_oe, ee);
        chk(pin_out & ee, eo & ee);
      end
    end
    $display("test mux done");
    wr(`EBPM_OFF_FUNC_EN, 32'h0c0, EBPM_OKAY);
    mreq <= 1'b1;
    wait_lvl(brel, 1'b1, 8);
    @(posedge mclk);
    chk(pin_out[14], 1'b0);
    chk(pin_oe[14], 1'b1);
    mreq <= 1'b0;
    wait_lvl(brel, 1'b0, 8);
    @(posedge mclk);
    chk(pin_out[14], 1'b1);
    wr(`EBPM_OFF_FUNC_EN, 32'h000, EBPM_OKAY);
    mreq <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(brel, 1'b0);
    mreq <= 1'b0;
    $display("test release done");
    wr(`EBPM_OFF_FUNC_EN, 32'h404, EBPM_OKAY);
    stop <= 1'b1;
    dreq <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(stop_o, 1'b1);
    chk(dreq_o, 1'b1);
    wr(`EBPM_OFF_FUNC_EN, 32'h000, EBPM_OKAY);
    repeat (3) @(posedge mclk);
    chk(stop_o, 1'b0);
    chk(dreq_o, 1'b0);
    {stop, dreq} <= 2'b00;
    $display("test dma inputs done");
    for (int e = 1; e >= 0; e--) begin
      wr(`EBPM_OFF_FUNC_EN, e ? 32'h020 : 32'h000, EBPM_OKAY);
      wlen <= 4'h4;
      cyc_go <= 1'b1;
      @(posedge mclk);
      cyc_go <= 1'b0;
      if (e) begin
        wait_lvl(bwait, 1'b1, 6);
        wait_lvl(bwait, 1'b0, 12);
      end else begin
        repeat (5) @(posedge mclk);
        chk(bwait, 1'b0);
      end
    end
    $display("test wait done");
    brd <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(rd_n, 1'b0);
    brd <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(rd_n, 1'b1);
    wr(`EBPM_OFF_PORT_OUT, 32'h20000, EBPM_OKAY);
    wr(`EBPM_OFF_FUNC_EN, 32'h000, EBPM_OKAY);
    repeat (3) @(posedge mclk);
    rd_chk(`EBPM_OFF_PIN_STAT, 32'h20000, 32'h20000, EBPM_OKAY);
    wr(`EBPM_OFF_MODE, 32'h0, EBPM_OKAY);
    wr(`EBPM_OFF_FUNC_EN, 32'h300, EBPM_OKAY);
    {wra, wrb, sub, slb, swe} <= 5'b10011;
    repeat (3) @(posedge mclk);
    rd_chk(`EBPM_OFF_PIN_STAT, 32'h30000, 32'h10000, EBPM_OKAY);
    wr(`EBPM_OFF_MODE, 32'h1, EBPM_OKAY);
    {sub, slb, swe} <= 3'b011;
    repeat (3) @(posedge mclk);
    rd_chk(`EBPM_OFF_PIN_STAT, 32'h70000, 32'h60000, EBPM_OKAY);
    $display("test strobes done");
    close_out();
  end
endmodule
`default_nettype wire
